//--- verilog/tas_pkg.sv
package tas_pkg;

  // Core clock rate and conversion period; the cycle count is derived.
  localparam longint CORE_CLK_HZ  = 25_000_000;
  localparam longint CONV_TIME_MS = 150;
  localparam int     CONV_CYCLES  = int'((CONV_TIME_MS * CORE_CLK_HZ) / 64'd1000);
  localparam int     CONV_CNT_W   = 22;

  // Highest serial clock rate the slave port is built for.
  localparam int     SCL_MAX_HZ   = 400_000;

  // Upper four slave address bits; the low three come from the select pins.
  localparam logic [3:0] ADDR_BASE = 4'h9;

  // Pointer values that select a register.
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG  = 2'h1;
  localparam logic [1:0] PTR_HYST = 2'h2;
  localparam logic [1:0] PTR_OVER = 2'h3;

  // Configuration field positions.
  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG_INT_MODE = 1;
  localparam int CFG_POLARITY = 2;
  localparam int CFG_FT_LO    = 3;
  localparam int CFG_FT_HI    = 4;
  localparam logic [7:0] CFG_WMASK = 8'h1F;

  // Values after reset.
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [15:0] OVER_RESET = 16'h7F80;
  localparam logic [15:0] HYST_RESET = 16'h7F00;
  localparam logic [8:0]  TEMP_RESET = 9'h000;

  // Consecutive out-of-limit results needed for each fault-count setting.
  localparam logic [2:0] FT_NEED_0 = 3'h1;
  localparam logic [2:0] FT_NEED_1 = 3'h2;
  localparam logic [2:0] FT_NEED_2 = 3'h4;
  localparam logic [2:0] FT_NEED_3 = 3'h6;

  typedef enum logic [8:0] {
    LS_IDLE  = 9'h001,
    LS_ADDR  = 9'h002,
    LS_AACK  = 9'h004,
    LS_PTR   = 9'h008,
    LS_PACK  = 9'h010,
    LS_WDAT  = 9'h020,
    LS_WACK  = 9'h040,
    LS_RDAT  = 9'h080,
    LS_RACK  = 9'h100
  } tas_lstate_e;

  // Address select pins travel together.
  typedef struct packed {
    logic addr_select_bit2;
    logic addr_select_bit1;
    logic addr_select_bit0;
  } tas_addr_sel_s;

  // Core domain state.
  typedef struct packed {
    logic [8:0]            temp_m;
    logic [8:0]            temp_s;
    logic                  sd_m;
    logic                  sd_s;
    logic [CONV_CNT_W-1:0] cnt;
    logic [8:0]            hold;
    logic                  tgl;
  } tas_core_s;

  // Link domain state.
  typedef struct packed {
    logic        scl_m, scl_s, scl_p;
    logic        sda_m, sda_s, sda_p;
    logic [2:0]  adr_m, adr_s;
    logic        tgl_m, tgl_s, tgl_p;
    tas_lstate_e st;
    logic [3:0]  bitcnt;
    logic [7:0]  sh;
    logic        rw;
    logic        ack_ok;
    logic [1:0]  ptr;
    logic        bidx;
    logic [7:0]  msb;
    logic [7:0]  cfg;
    logic [15:0] over_limit_threshold;
    logic [15:0] hysteresis_threshold;
    logic [8:0]  temp;
    logic [2:0]  over_cnt;
    logic [2:0]  under_cnt;
    logic        active;
    logic        arm_hyst;
    logic        sda_oe;
    logic        alert_oe;
    logic        od_low;
  } tas_link_s;

endpackage : tas_pkg

//--- verilog/tas_sensor_core.sv
`timescale 1ns/100ps
// Function
// - Temperature comes from a 9-bit converter, half a degree per step.
// - Results are in degrees centigrade; host handles Fahrenheit.
// - Conversions start right after reset with no command.
// - Serial port works with master clocks up to 400 kHz; master stays below.
// - Low three slave address bits come from three select pins.
// - Master can read the latest temperature result at any time.
// - 16-bit read/write over-limit threshold, compared with every new result.
// - 16-bit read/write hysteresis threshold marks where the alarm turns off.
// - Alert has two modes, comparator and interrupt, chosen by configuration.
// - Alert activates when temperature exceeds the programmed limits.
// - Interrupt mode gives an alert event on over-limit, not a level.
// - Comparator mode acts as thermostat between over-limit and hysteresis.
// - Alert pin is open drain: pulled low or released.
// - Serial clock is input only; serial data is open drain two-way.
// - Result is two's complement in bits 15 to 7; lower bits zero.
// - Fault count field at bits 4:3 selects 1, 2, 4 or 6; resets to 1.
// - Interrupt mode alert clears only on a register read or shutdown entry.
// - Comparator alert stays active until temperature drops below hysteresis.
module tas_sensor_core #(
  parameter int CONV_CYCLES_P = tas_pkg::CONV_CYCLES
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   link_clk,
  input  wire logic [8:0]             temp_sense,
  input  wire tas_pkg::tas_addr_sel_s addr_sel,
  input  wire logic                   scl_pin,
  input  wire logic                   sda_pin,
  output logic                        sda_drv,
  output logic                        sda_oe,
  output logic                        over_limit_alert,
  output logic                        over_limit_alert_oe
);
  import tas_pkg::*;

  tas_core_s c_q;
  tas_core_s c_d;
  tas_link_s l_q;
  tas_link_s l_d;
  logic      rst_m_q;
  logic      rst_l_q;

  // Core domain: paces conversions and samples the converter code.
  always_comb begin
    c_d        = c_q;
    c_d.temp_m = temp_sense;
    c_d.temp_s = c_q.temp_m;
    c_d.sd_m   = l_q.cfg[CFG_SHUTDOWN];
    c_d.sd_s   = c_q.sd_m;
    if (c_q.cnt == CONV_CNT_W'(CONV_CYCLES_P - 1)) begin
      c_d.cnt  = '0;
      c_d.hold = c_q.temp_s;
      c_d.tgl  = ~c_q.tgl;
    end else if (!(c_q.sd_s && c_q.cnt == '0)) begin
      c_d.cnt  = c_q.cnt + 1'b1;
    end
  end

  // Core domain register; counting begins at the first edge after reset.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      c_q <= '{temp_m: 9'h000, temp_s: 9'h000, sd_m: 1'b0, sd_s: 1'b0,
               cnt: '0, hold: TEMP_RESET, tgl: 1'b0};
    end else begin
      c_q <= c_d;
    end
  end

  // Reset is carried into the link domain by two flip-flops.
  always_ff @(posedge link_clk) begin
    rst_m_q <= reset;
    rst_l_q <= rst_m_q;
  end

  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic        new_res;
  logic        rd_evt;
  logic [15:0] rd_word;
  logic [7:0]  rd_byte;
  logic [2:0]  ft_need;
  logic        over;
  logic        under;
  logic        addr_hit;

  // Edge and bus condition decode on synchronised pins.
  always_comb begin
    scl_rise   = l_q.scl_s & ~l_q.scl_p;
    scl_fall   = ~l_q.scl_s & l_q.scl_p;
    start_cond = l_q.scl_s & l_q.scl_p & l_q.sda_p & ~l_q.sda_s;
    stop_cond  = l_q.scl_s & l_q.scl_p & ~l_q.sda_p & l_q.sda_s;
    new_res    = l_q.tgl_s ^ l_q.tgl_p;
    addr_hit   = (l_q.sh[7:1] == {ADDR_BASE, l_q.adr_s});
    case (l_q.ptr)
      PTR_TEMP: rd_word = {l_q.temp, 7'h00};
      PTR_CFG:  rd_word = {l_q.cfg, l_q.cfg};
      PTR_HYST: rd_word = l_q.hysteresis_threshold;
      default:  rd_word = l_q.over_limit_threshold;
    endcase
    // A read always opens with the high byte, whatever an earlier frame left.
    rd_byte = rd_word[15:8];
    case (l_q.cfg[CFG_FT_HI:CFG_FT_LO])
      2'h0:    ft_need = FT_NEED_0;
      2'h1:    ft_need = FT_NEED_1;
      2'h2:    ft_need = FT_NEED_2;
      default: ft_need = FT_NEED_3;
    endcase
    over  = $signed(l_q.temp) > $signed(l_q.over_limit_threshold[15:7]);
    under = $signed(l_q.temp) < $signed(l_q.hysteresis_threshold[15:7]);
  end

  // Link domain: serial slave, register file and alarm logic.
  always_comb begin
    l_d        = l_q;
    rd_evt     = 1'b0;
    l_d.scl_m  = scl_pin;
    l_d.scl_s  = l_q.scl_m;
    l_d.scl_p  = l_q.scl_s;
    l_d.sda_m  = sda_pin;
    l_d.sda_s  = l_q.sda_m;
    l_d.sda_p  = l_q.sda_s;
    l_d.adr_m  = {addr_sel.addr_select_bit2, addr_sel.addr_select_bit1,
                  addr_sel.addr_select_bit0};
    l_d.adr_s  = l_q.adr_m;
    l_d.tgl_m  = c_q.tgl;
    l_d.tgl_s  = l_q.tgl_m;
    l_d.tgl_p  = l_q.tgl_s;
    l_d.od_low = 1'b0;
    if (new_res) begin
      l_d.temp = c_q.hold;
    end

    // Receive states shift on the rising serial clock.
    if (scl_rise && (l_q.st inside {LS_ADDR, LS_PTR, LS_WDAT})) begin
      l_d.sh     = {l_q.sh[6:0], l_q.sda_s};
      l_d.bitcnt = l_q.bitcnt + 1'b1;
    end
    if (scl_rise && l_q.st == LS_RACK) begin
      l_d.ack_ok = ~l_q.sda_s;
    end
    if (scl_rise && l_q.st == LS_RDAT) begin
      l_d.bitcnt = l_q.bitcnt + 1'b1;
    end

    // Byte and acknowledge sequencing on the falling serial clock.
    if (scl_fall) begin
      case (l_q.st)
        LS_ADDR: begin
          if (l_q.bitcnt == 4'h8) begin
            if (addr_hit) begin
              l_d.sda_oe = 1'b1;
              l_d.rw     = l_q.sh[0];
              l_d.st     = LS_AACK;
            end else begin
              l_d.st     = LS_IDLE;
            end
          end
        end
        LS_AACK: begin
          l_d.bitcnt = 4'h0;
          l_d.bidx   = 1'b0;
          if (l_q.rw) begin
            rd_evt     = 1'b1;
            l_d.sh     = rd_byte;
            l_d.sda_oe = ~rd_byte[7];
            l_d.st     = LS_RDAT;
          end else begin
            l_d.sda_oe = 1'b0;
            l_d.st     = LS_PTR;
          end
        end
        LS_PTR: begin
          if (l_q.bitcnt == 4'h8) begin
            l_d.sda_oe = 1'b1;
            l_d.ptr    = l_q.sh[1:0];
            l_d.st     = LS_PACK;
          end
        end
        LS_PACK, LS_WACK: begin
          l_d.sda_oe = 1'b0;
          l_d.bitcnt = 4'h0;
          l_d.st     = LS_WDAT;
        end
        LS_WDAT: begin
          if (l_q.bitcnt == 4'h8) begin
            l_d.sda_oe = 1'b1;
            l_d.st     = LS_WACK;
            l_d.bidx   = ~l_q.bidx;
            if (l_q.ptr == PTR_CFG) begin
              l_d.cfg = l_q.sh & CFG_WMASK;
            end else if (!l_q.bidx) begin
              l_d.msb = l_q.sh;
            end else if (l_q.ptr == PTR_OVER) begin
              l_d.over_limit_threshold = {l_q.msb, l_q.sh[7], 7'h00};
            end else if (l_q.ptr == PTR_HYST) begin
              l_d.hysteresis_threshold = {l_q.msb, l_q.sh[7], 7'h00};
            end
          end
        end
        LS_RDAT: begin
          if (l_q.bitcnt == 4'h8) begin
            l_d.sda_oe = 1'b0;
            l_d.st     = LS_RACK;
          end else begin
            l_d.sh     = {l_q.sh[6:0], 1'b0};
            l_d.sda_oe = ~l_q.sh[6];
          end
        end
        LS_RACK: begin
          l_d.bitcnt = 4'h0;
          if (l_q.ack_ok) begin
            l_d.bidx   = ~l_q.bidx;
            l_d.sh     = l_q.bidx ? rd_word[15:8] : rd_word[7:0];
            l_d.sda_oe = l_q.bidx ? ~rd_word[15] : ~rd_word[7];
            l_d.st     = LS_RDAT;
          end else begin
            l_d.st     = LS_IDLE;
          end
        end
        LS_IDLE: begin
          l_d.sda_oe = 1'b0;
        end
        default: begin
          l_d.sda_oe = 1'b0;
          l_d.st     = LS_IDLE;
        end
      endcase
    end

    // Start or stop abandons any transfer and frees the data line.
    if (start_cond) begin
      l_d.st     = LS_ADDR;
      l_d.bitcnt = 4'h0;
      l_d.sda_oe = 1'b0;
    end else if (stop_cond) begin
      l_d.st     = LS_IDLE;
      l_d.sda_oe = 1'b0;
    end

    // Interrupt mode clears on a read or on entry into shutdown.
    if (l_q.cfg[CFG_INT_MODE] &&
        (rd_evt || (l_d.cfg[CFG_SHUTDOWN] && !l_q.cfg[CFG_SHUTDOWN]))) begin
      l_d.active = 1'b0;
    end

    // Fault queue and alert decision, once per new result; set wins over clear.
    if (new_res) begin
      l_d.over_cnt  = 3'h0;
      l_d.under_cnt = 3'h0;
      if (over) begin
        l_d.over_cnt  = (l_q.over_cnt == FT_NEED_3) ? l_q.over_cnt : l_q.over_cnt + 1'b1;
      end
      if (under) begin
        l_d.under_cnt = (l_q.under_cnt == FT_NEED_3) ? l_q.under_cnt : l_q.under_cnt + 1'b1;
      end
      if (l_q.cfg[CFG_INT_MODE]) begin
        if (!l_q.arm_hyst && l_d.over_cnt >= ft_need) begin
          l_d.active   = 1'b1;
          l_d.arm_hyst = 1'b1;
        end else if (l_q.arm_hyst && l_d.under_cnt >= ft_need) begin
          l_d.active   = 1'b1;
          l_d.arm_hyst = 1'b0;
        end
      end else begin
        l_d.arm_hyst = 1'b0;
        if (!l_q.active && l_d.over_cnt >= ft_need) begin
          l_d.active = 1'b1;
        end else if (l_q.active && l_d.under_cnt >= ft_need) begin
          l_d.active = 1'b0;
        end
      end
    end

    // Open-drain pin pulls low when the alarm level demands it.
    l_d.alert_oe = l_q.active ^ l_q.cfg[CFG_POLARITY];
  end

  // Link domain register.
  always_ff @(posedge link_clk) begin
    if (rst_l_q) begin
      l_q <= '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
               sda_p: 1'b1, adr_m: 3'h0, adr_s: 3'h0, tgl_m: 1'b0, tgl_s: 1'b0,
               tgl_p: 1'b0, st: LS_IDLE, bitcnt: 4'h0, sh: 8'h00, rw: 1'b0,
               ack_ok: 1'b0, ptr: PTR_TEMP, bidx: 1'b0, msb: 8'h00,
               cfg: CFG_RESET, over_limit_threshold: OVER_RESET,
               hysteresis_threshold: HYST_RESET, temp: TEMP_RESET,
               over_cnt: 3'h0, under_cnt: 3'h0, active: 1'b0, arm_hyst: 1'b0,
               sda_oe: 1'b0, alert_oe: 1'b0, od_low: 1'b0};
    end else begin
      l_q <= l_d;
    end
  end

  // Outputs straight from flip-flops.
  assign sda_drv             = l_q.od_low;
  assign sda_oe              = l_q.sda_oe;
  assign over_limit_alert    = l_q.od_low;
  assign over_limit_alert_oe = l_q.alert_oe;

  // Acknowledge of a matching address: data line pulled for one bit slot.
  sequence s_addr_match;
    scl_fall && l_q.st == LS_ADDR && l_q.bitcnt == 4'h8 && addr_hit && !start_cond;
  endsequence

  sequence s_ack_drive;
    ##1 (l_q.sda_oe && l_q.st == LS_AACK);
  endsequence

  a_addr_ack: assert property (@(posedge link_clk) disable iff (rst_l_q)
    s_addr_match |-> s_ack_drive)
    else $error("Matching address was not acknowledged.");

  a_addr_pins: assert property (@(posedge link_clk) disable iff (rst_l_q)
    $rose(l_q.st == LS_AACK) |-> $past(l_q.sh[3:1]) == l_q.adr_s)
    else $error("Address acknowledged with wrong select bits.");

  // The core reset also masks the first link edges, before the reset chain has filled.
  a_od_drive: assert property (@(posedge link_clk) disable iff (rst_l_q || reset)
    !sda_drv && !over_limit_alert)
    else $error("Open-drain pin driven high.");

  a_alert_level: assert property (@(posedge link_clk) disable iff (rst_l_q)
    ##1 over_limit_alert_oe == ($past(l_q.active) ^ $past(l_q.cfg[CFG_POLARITY])))
    else $error("Alert pin does not follow alarm and polarity.");

  a_temp_low: assert property (@(posedge link_clk) disable iff (rst_l_q)
    l_q.ptr == PTR_TEMP |-> rd_word[6:0] == 7'h00)
    else $error("Unused temperature bits not zero.");

  a_ft_reset: assert property (@(posedge link_clk)
    $fell(rst_l_q) |-> l_q.cfg[CFG_FT_HI:CFG_FT_LO] == 2'h0 && ft_need == FT_NEED_0)
    else $error("Fault count not one after reset.");

  a_int_clear: assert property (@(posedge link_clk) disable iff (rst_l_q)
    rd_evt && l_q.cfg[CFG_INT_MODE] && !new_res |=> !l_q.active)
    else $error("Read did not clear interrupt alert.");

  a_alarm_cause: assert property (@(posedge link_clk) disable iff (rst_l_q)
    $rose(l_q.active) |-> $past(new_res))
    else $error("Alarm raised without a new result.");

  a_cmp_hold: assert property (@(posedge link_clk) disable iff (rst_l_q)
    l_q.active && !l_q.cfg[CFG_INT_MODE] && !l_d.cfg[CFG_INT_MODE] && !new_res
    |=> l_q.active)
    else $error("Comparator alert dropped without a result.");

  a_conv_tick: assert property (@(posedge core_clk) disable iff (reset)
    !c_q.sd_s && c_q.cnt == CONV_CNT_W'(CONV_CYCLES_P - 1) |=> c_q.tgl != $past(c_q.tgl))
    else $error("Conversion did not complete at period end.");

endmodule : tas_sensor_core

//--- tb/tas_bus_master.sv
`timescale 1ns/100ps
module tas_bus_master #(
  parameter int HALF_NS = 1280
) (
  output logic    scl,
  output logic    sda_low,
  input  wire logic sda_wire
);
  // Both lines idle released; the clock stands still between frames.
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Start or repeated start: data falls while the clock is high.
  task automatic start_cond();
    sda_low = 1'b0;
    #(HALF_NS) scl = 1'b1;
    #(HALF_NS) sda_low = 1'b1;
    #(HALF_NS) scl = 1'b0;
  endtask : start_cond

  // Stop: data rises while the clock is high, then both stay released.
  task automatic stop_cond();
    sda_low = 1'b1;
    #(HALF_NS) scl = 1'b1;
    #(HALF_NS) sda_low = 1'b0;
    #(HALF_NS);
  endtask : stop_cond

  // One bit: data set in the low phase, held through the high phase.
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    #(HALF_NS) scl = 1'b1;
    #(HALF_NS / 2) r = sda_wire;
    #(HALF_NS / 2) scl = 1'b0;
  endtask : bit_io

  // Eight bits MSB first, then the acknowledge slot.
  task automatic xfer(input logic [7:0] tx, input logic rel_ack,
                      output logic [7:0] rx, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(rel_ack, a);
    ack = ~a;
  endtask : xfer
endmodule : tas_bus_master

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import tas_pkg::*;

  localparam int CONV_P    = 200;
  localparam int LIMIT_CYC = 90000;

  logic          core_clk = 1'b0;
  logic          link_clk = 1'b0;
  logic          reset;
  logic [8:0]    temp_sense;
  tas_addr_sel_s addr_sel;
  logic          scl;
  logic          m_sda_low;
  wire logic     sda_wire;
  logic          sda_drv;
  logic          sda_oe;
  logic          alert_drv;
  logic          alert_oe;
  int            mismatches = 0;
  int            total_checks = 0;
  int            cycles = 0;

  // The data line has a pull-up, so it is low while either party pulls it.
  assign sda_wire = ~(sda_oe | m_sda_low);

  // Core clock at 25 MHz and an unrelated 6 ns link clock.
  always #20 core_clk = ~core_clk;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  tas_sensor_core #(.CONV_CYCLES_P(CONV_P)) dut_u (
    .core_clk(core_clk), .reset(reset), .link_clk(link_clk),
    .temp_sense(temp_sense), .addr_sel(addr_sel), .scl_pin(scl), .sda_pin(sda_wire),
    .sda_drv(sda_drv), .sda_oe(sda_oe), .over_limit_alert(alert_drv),
    .over_limit_alert_oe(alert_oe)
  );

  tas_bus_master master_u (.scl(scl), .sda_low(m_sda_low), .sda_wire(sda_wire));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // A run that hangs is cut short and judged as failed.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT_CYC) begin
      mismatches++;
      $display("mismatch at %0t: run timed out", $time);
      end_sim();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wait_conv(input int n);
    repeat (n * CONV_P) @(negedge core_clk);
  endtask : wait_conv

  // Pointer set, then one or two data bytes, every byte acknowledged.
  task automatic wr_reg(input logic [1:0] ptr, input logic [15:0] val, input logic two);
    logic [7:0] rx;
    logic       a0, a1, a2, a3;
    @(negedge core_clk);
    master_u.start_cond();
    master_u.xfer({ADDR_BASE, addr_sel, 1'b0}, 1'b1, rx, a0);
    master_u.xfer({6'h00, ptr}, 1'b1, rx, a1);
    master_u.xfer(two ? val[15:8] : val[7:0], 1'b1, rx, a2);
    a3 = 1'b1;
    if (two) begin
      master_u.xfer(val[7:0], 1'b1, rx, a3);
    end
    master_u.stop_cond();
    check({15'h0000, a0 & a1 & a2 & a3}, 16'h0001, "write acks");
  endtask : wr_reg

  // Pointer set, repeated start, then a read closed by a refused acknowledge.
  task automatic rd_reg(input logic [1:0] ptr, input logic two, output logic [15:0] v);
    logic [7:0] b1, b2, rx;
    logic       a0, a1, a2, ad;
    @(negedge core_clk);
    master_u.start_cond();
    master_u.xfer({ADDR_BASE, addr_sel, 1'b0}, 1'b1, rx, a0);
    master_u.xfer({6'h00, ptr}, 1'b1, rx, a1);
    master_u.start_cond();
    master_u.xfer({ADDR_BASE, addr_sel, 1'b1}, 1'b1, rx, a2);
    master_u.xfer(8'hFF, ~two, b1, ad);
    b2 = 8'h00;
    if (two) begin
      master_u.xfer(8'hFF, 1'b1, b2, ad);
    end
    master_u.stop_cond();
    v = two ? {b1, b2} : {8'h00, b1};
    check({15'h0000, a0 & a1 & a2}, 16'h0001, "read acks");
  endtask : rd_reg

  // Register values after reset.
  task automatic t_reset_vals();
    logic [15:0] v;
    rd_reg(PTR_OVER, 1'b1, v);
    check(v, 16'h7F80, "over reset");
    rd_reg(PTR_HYST, 1'b1, v);
    check(v, 16'h7F00, "hyst reset");
    rd_reg(PTR_CFG, 1'b0, v);
    check(v, 16'h0000, "cfg reset");
    $display("test reset_vals done");
  endtask : t_reset_vals

  // A foreign address is ignored; the select pins move the address.
  task automatic t_address();
    logic [7:0]  rx;
    logic        ack;
    logic [15:0] v;
    @(negedge core_clk);
    master_u.start_cond();
    master_u.xfer({ADDR_BASE, 3'b010, 1'b0}, 1'b1, rx, ack);
    master_u.stop_cond();
    check({15'h0000, ack}, 16'h0000, "foreign address");
    addr_sel = 3'b010;
    repeat (10) @(negedge core_clk);
    rd_reg(PTR_HYST, 1'b1, v);
    check(v, 16'h7F00, "moved address");
    $display("test address done");
  endtask : t_address

  // Results of both signs land in bits 15 to 7 without any command.
  task automatic t_temp();
    logic [15:0] v;
    rd_reg(PTR_TEMP, 1'b1, v);
    check(v, {9'h032, 7'h00}, "first result");
    temp_sense = 9'h1CE;
    wait_conv(2);
    rd_reg(PTR_TEMP, 1'b1, v);
    check(v, {9'h1CE, 7'h00}, "negative result");
    $display("test temp done");
  endtask : t_temp

  // Thermostat with a fault count of six in both directions.
  task automatic t_comparator();
    logic [15:0] v;
    wr_reg(PTR_OVER, 16'h19FF, 1'b1);
    wr_reg(PTR_HYST, 16'h1400, 1'b1);
    rd_reg(PTR_OVER, 1'b1, v);
    check(v, 16'h1980, "over readback");
    wr_reg(PTR_CFG, 16'h0018, 1'b0);
    temp_sense = 9'h034;
    wait_conv(3);
    check({15'h0000, alert_oe}, 16'h0000, "too few faults");
    wait_conv(5);
    check({15'h0000, alert_oe}, 16'h0001, "alarm on");
    temp_sense = 9'h02C;
    wait_conv(8);
    check({15'h0000, alert_oe}, 16'h0001, "alarm held");
    temp_sense = 9'h026;
    wait_conv(8);
    check({15'h0000, alert_oe}, 16'h0000, "alarm off");
    $display("test comparator done");
  endtask : t_comparator

  // Events cleared by a read and by shutdown, alternating limits.
  task automatic t_interrupt();
    logic [15:0] v;
    wr_reg(PTR_CFG, 16'h0002, 1'b0);
    temp_sense = 9'h034;
    wait_conv(3);
    check({15'h0000, alert_oe}, 16'h0001, "over event");
    rd_reg(PTR_TEMP, 1'b1, v);
    check({15'h0000, alert_oe}, 16'h0000, "read clear");
    wait_conv(3);
    check({15'h0000, alert_oe}, 16'h0000, "no level");
    temp_sense = 9'h026;
    wait_conv(3);
    check({15'h0000, alert_oe}, 16'h0001, "hyst event");
    wr_reg(PTR_CFG, 16'h0003, 1'b0);
    check({15'h0000, alert_oe}, 16'h0000, "shutdown clear");
    $display("test interrupt done");
  endtask : t_interrupt

  // Shutdown freezes the result; inverted polarity with a fault count of four.
  task automatic t_polarity();
    logic [15:0] v;
    wait_conv(2);
    temp_sense = 9'h034;
    wait_conv(3);
    rd_reg(PTR_TEMP, 1'b1, v);
    check(v, {9'h026, 7'h00}, "shutdown hold");
    temp_sense = 9'h02C;
    wr_reg(PTR_CFG, 16'h0014, 1'b0);
    check({15'h0000, alert_oe}, 16'h0001, "inverted idle");
    temp_sense = 9'h034;
    wait_conv(2);
    check({15'h0000, alert_oe}, 16'h0001, "two of four faults");
    wait_conv(3);
    check({15'h0000, alert_oe}, 16'h0000, "inverted alarm");
    check({14'h0000, sda_drv, alert_drv}, 16'h0000, "open drain levels");
    $display("test polarity done");
  endtask : t_polarity

  // Reset, then the scenarios in turn.
  initial begin
    reset      = 1'b1;
    temp_sense = 9'h032;
    addr_sel   = 3'b101;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    repeat (10) @(negedge core_clk);
    t_reset_vals();
    t_address();
    t_temp();
    t_comparator();
    t_interrupt();
    t_polarity();
    end_sim();
  end
endmodule : testbench
